// file: hdl/seq_pkg.sv
// Constants, types and helpers shared by the status event and error queue block
//==============================================================================
// What this block does
// - Event bits latch at 1 until read or cleared
// - Reading event register returns then clears it
// - Power-up and clear-status clear event registers
// - Event AND enable forms summary bit
// - Writing zero clears all enable bits
// - Enable registers are sixteen bits wide, the standard one eight
// - Power-up and preset clear enable registers
// - Query responses enter first-in first-out queue
// - Message available follows output queue fill
// - Error events queue and set error available
// - Error queue holds ten, oldest read first
// - Last free slot takes overflow code 350
// - Empty error queue reads code zero
// - Entries carry signed codes
// - Power-up enables errors, disables status codes
// - Enable list replaces, disable list removes
// - Lists take single codes and ranges
// - Empty enable list disables every code
// - Next, all, count and clear queue reads
// - Power-up and clear-status empty error queue
// - Error available B2, master summary B6
package seq_pkg;

  //============================================================================
  // Register map, byte addresses
  localparam logic [7:0] OFF_CTRL       = 8'h00;
  localparam logic [7:0] OFF_STB        = 8'h04;
  localparam logic [7:0] OFF_EV_STD     = 8'h10;
  localparam logic [7:0] OFF_EV_OPER    = 8'h14;
  localparam logic [7:0] OFF_EV_MEAS    = 8'h18;
  localparam logic [7:0] OFF_EV_QUES    = 8'h1C;
  localparam logic [7:0] OFF_EN_STD     = 8'h20;
  localparam logic [7:0] OFF_EN_OPER    = 8'h24;
  localparam logic [7:0] OFF_EN_MEAS    = 8'h28;
  localparam logic [7:0] OFF_EN_QUES    = 8'h2C;
  localparam logic [7:0] OFF_OQ_DATA    = 8'h30;
  localparam logic [7:0] OFF_OQ_COUNT   = 8'h34;
  localparam logic [7:0] OFF_EQ_NEXT    = 8'h38;
  localparam logic [7:0] OFF_EQ_CODE    = 8'h3C;
  localparam logic [7:0] OFF_EQ_ALL     = 8'h40;
  localparam logic [7:0] OFF_EQ_COUNT   = 8'h44;
  localparam logic [7:0] OFF_LIST_RANGE = 8'h48;
  localparam logic [7:0] OFF_LIST_CMD   = 8'h4C;
  localparam logic [7:0] OFF_LIST_QUERY = 8'h50;

  //============================================================================
  // Field positions
  localparam int CTRL_CLS       = 0;
  localparam int CTRL_PRESET    = 1;
  localparam int CTRL_EQ_CLEAR  = 2;
  localparam int CTRL_OQ_CLEAR  = 3;
  localparam int LC_ENABLE_NEW  = 0;
  localparam int LC_ENABLE_ADD  = 1;
  localparam int LC_DISABLE     = 2;
  localparam int LC_ENABLE_NONE = 3;
  localparam int SB_MEAS        = 0;
  localparam int SB_EAV         = 2;
  localparam int SB_QUES        = 3;
  localparam int SB_MAV         = 4;
  localparam int SB_STD         = 5;
  localparam int SB_MSS         = 6;
  localparam int SB_OPER        = 7;
  localparam int STD_QUERY_ERR  = 2;
  localparam int EQ_ALL_CNT_LSB = 16;

  //============================================================================
  // Sizes and codes
  localparam logic [3:0]  EQ_DEPTH     = 4'hA;
  localparam logic [4:0]  OQ_DEPTH     = 5'h10;
  localparam logic [15:0] EQ_OVF_CODE  = 16'h015E;
  localparam logic [15:0] EQ_NO_ERROR  = 16'h0000;
  localparam int          LIST_N       = 2048;
  localparam int          LIST_BIAS    = 1024;
  localparam int          STAT_FIRST   = 100;
  localparam int          STAT_LAST    = 199;

  //============================================================================
  // Types
  typedef struct packed {
    logic [7:0]  std;
    logic [15:0] oper;
    logic [15:0] meas;
    logic [15:0] ques;
  } seq_evt_t;

  typedef struct packed {
    logic signed [15:0] last;
    logic signed [15:0] first;
  } seq_range_t;

  // Status codes start disabled, every other code in the list span enabled
  function automatic logic [LIST_N-1:0] list_reset();
    logic [LIST_N-1:0] v;
    v = '0;
    for (int i = 0; i < LIST_N; i++)
    begin
      v[i] = !((i - LIST_BIAS) >= STAT_FIRST && (i - LIST_BIAS) <= STAT_LAST);
    end
    return v;
  endfunction

  localparam logic [LIST_N-1:0] LIST_RESET = list_reset();

  // Codes outside the list span are never enabled
  function automatic logic code_in_span(input logic [15:0] c);
    return (c[15:10] == 6'h00) || (c[15:10] == 6'h3F);
  endfunction

  function automatic logic [10:0] code_index(input logic [15:0] c);
    return {~c[10], c[9:0]};
  endfunction

endpackage

// file: hdl/seq_err_fifo.sv
// Error and status message queue with overflow marker
`timescale 1ns/1ns
module seq_err_fifo (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        push,
  input  wire logic [15:0] push_code,
  input  wire logic        pop,
  input  wire logic        clear,
  output logic      [15:0] head_code,
  output logic      [3:0]  count
);

  logic [15:0] mem_q [10];
  logic [15:0] mem_d [10];
  logic [3:0]  wr_q;
  logic [3:0]  wr_d;
  logic [3:0]  rd_q;
  logic [3:0]  rd_d;
  logic [3:0]  cnt_q;
  logic [3:0]  cnt_d;

  function automatic logic [3:0] wrap_inc(input logic [3:0] p);
    return (p == seq_pkg::EQ_DEPTH - 4'h1) ? 4'h0 : 4'(p + 4'h1);
  endfunction

  //============================================================================
  // Next state
  always_comb
  begin
    mem_d = mem_q;
    wr_d  = wr_q;
    rd_d  = rd_q;
    cnt_d = cnt_q;
    // Clear first, so an event in the clearing cycle still lands
    if (clear)
    begin
      wr_d  = 4'h0;
      rd_d  = 4'h0;
      cnt_d = 4'h0;
    end
    else if (pop && cnt_q != 4'h0)
    begin
      rd_d  = wrap_inc(rd_q);
      cnt_d = 4'(cnt_q - 4'h1);
    end
    if (push && cnt_d < seq_pkg::EQ_DEPTH)
    begin
      mem_d[wr_d] = (cnt_d == seq_pkg::EQ_DEPTH - 4'h1) ? seq_pkg::EQ_OVF_CODE : push_code;
      wr_d        = wrap_inc(wr_d);
      cnt_d       = 4'(cnt_d + 4'h1);
    end
  end

  //============================================================================
  // Registers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < 10; i++)
      begin
        mem_q[i] <= 16'h0000;
      end
      wr_q  <= 4'h0;
      rd_q  <= 4'h0;
      cnt_q <= 4'h0;
    end
    else
    begin
      mem_q <= mem_d;
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  assign head_code = (cnt_q == 4'h0) ? seq_pkg::EQ_NO_ERROR : mem_q[rd_q];
  assign count     = cnt_q;

endmodule

// file: hdl/seq_top.sv
// Status event registers, enable registers, output queue and error queue on APB
//
// Chosen here: the placing of the registers and the APB register port.
`timescale 1ns/1ns
module seq_top (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire seq_pkg::seq_evt_t evt_set,
  input  wire logic              err_valid,
  input  wire logic [15:0]       err_code,
  input  wire logic              resp_valid,
  input  wire logic [31:0]       resp_data,
  output logic                   resp_ready,
  output logic      [7:0]        status_byte,
  output logic                   master_summary_flag
);

  //============================================================================
  // Declarations
  seq_pkg::seq_evt_t      ev_q;
  seq_pkg::seq_evt_t      ev_d;
  seq_pkg::seq_evt_t      en_q;
  seq_pkg::seq_evt_t      en_d;
  seq_pkg::seq_range_t    range_q;
  seq_pkg::seq_range_t    range_d;
  logic [seq_pkg::LIST_N-1:0] list_q;
  logic [seq_pkg::LIST_N-1:0] list_d;
  logic [31:0]            oq_mem_q [16];
  logic [31:0]            oq_mem_d [16];
  logic [3:0]             oq_wr_q;
  logic [3:0]             oq_wr_d;
  logic [3:0]             oq_rd_q;
  logic [3:0]             oq_rd_d;
  logic [4:0]             oq_cnt_q;
  logic [4:0]             oq_cnt_d;
  logic [31:0]            rdata_q;
  logic [31:0]            rdata_d;
  logic [7:0]             stb_q;
  logic [7:0]             stb_d;
  logic                   setup;
  logic                   access;
  logic                   mapped;
  logic                   wr_en;
  logic                   rd_en;
  logic                   cls;
  logic                   preset;
  logic                   eq_push;
  logic                   eq_pop;
  logic                   eq_clear;
  logic [15:0]            eq_head;
  logic [3:0]             eq_count;
  logic                   oq_pop;
  logic                   oq_push;
  logic                   query_err;

  //============================================================================
  // Helpers
  function automatic logic addr_mapped(input logic [7:0] a);
    unique case (a)
      seq_pkg::OFF_CTRL, seq_pkg::OFF_STB,
      seq_pkg::OFF_EV_STD, seq_pkg::OFF_EV_OPER, seq_pkg::OFF_EV_MEAS, seq_pkg::OFF_EV_QUES,
      seq_pkg::OFF_EN_STD, seq_pkg::OFF_EN_OPER, seq_pkg::OFF_EN_MEAS, seq_pkg::OFF_EN_QUES,
      seq_pkg::OFF_OQ_DATA, seq_pkg::OFF_OQ_COUNT, seq_pkg::OFF_EQ_NEXT, seq_pkg::OFF_EQ_CODE,
      seq_pkg::OFF_EQ_ALL, seq_pkg::OFF_EQ_COUNT, seq_pkg::OFF_LIST_RANGE, seq_pkg::OFF_LIST_CMD,
      seq_pkg::OFF_LIST_QUERY: return 1'b1;
      default:                 return 1'b0;
    endcase
  endfunction

  function automatic logic summary16(input logic [15:0] ev, input logic [15:0] en);
    return |(ev & en);
  endfunction

  function automatic logic [3:0] oq_inc(input logic [3:0] p);
    return 4'(p + 4'h1);
  endfunction

  function automatic logic code_enabled(input logic [15:0] c, input logic [seq_pkg::LIST_N-1:0] l);
    return seq_pkg::code_in_span(c) && l[seq_pkg::code_index(c)];
  endfunction

  //============================================================================
  // APB decode; zero wait states, errors on unmapped addresses
  assign setup   = psel && !penable;
  assign access  = psel && penable;
  assign mapped  = addr_mapped(paddr);
  assign pready  = 1'b1;
  assign pslverr = access && !mapped;
  assign wr_en   = access && pwrite && mapped;
  assign rd_en   = access && !pwrite && mapped;
  assign prdata  = rdata_q;
  assign cls     = wr_en && paddr == seq_pkg::OFF_CTRL && pwdata[seq_pkg::CTRL_CLS];
  assign preset  = wr_en && paddr == seq_pkg::OFF_CTRL && pwdata[seq_pkg::CTRL_PRESET];

  //============================================================================
  // Read data, captured in the setup phase
  // Read-clear uses this snapshot, so a bit set after it survives
  always_comb
  begin
    rdata_d = rdata_q;
    if (setup)
    begin
      rdata_d = 32'h0000_0000;
      if (!pwrite)
      begin
        unique case (paddr)
          seq_pkg::OFF_STB:        rdata_d[7:0]   = stb_q;
          seq_pkg::OFF_EV_STD:     rdata_d[7:0]   = ev_q.std;
          seq_pkg::OFF_EV_OPER:    rdata_d[15:0]  = ev_q.oper;
          seq_pkg::OFF_EV_MEAS:    rdata_d[15:0]  = ev_q.meas;
          seq_pkg::OFF_EV_QUES:    rdata_d[15:0]  = ev_q.ques;
          seq_pkg::OFF_EN_STD:     rdata_d[7:0]   = en_q.std;
          seq_pkg::OFF_EN_OPER:    rdata_d[15:0]  = en_q.oper;
          seq_pkg::OFF_EN_MEAS:    rdata_d[15:0]  = en_q.meas;
          seq_pkg::OFF_EN_QUES:    rdata_d[15:0]  = en_q.ques;
          seq_pkg::OFF_OQ_DATA:    rdata_d        = (oq_cnt_q != 5'h00) ? oq_mem_q[oq_rd_q] : 32'h0000_0000;
          seq_pkg::OFF_OQ_COUNT:   rdata_d[4:0]   = oq_cnt_q;
          seq_pkg::OFF_EQ_NEXT,
          seq_pkg::OFF_EQ_CODE:    rdata_d        = {{16{eq_head[15]}}, eq_head};
          seq_pkg::OFF_EQ_ALL:
          begin
            rdata_d[15:0] = eq_head;
            rdata_d[seq_pkg::EQ_ALL_CNT_LSB +: 4] = eq_count;
          end
          seq_pkg::OFF_EQ_COUNT:   rdata_d[3:0]   = eq_count;
          seq_pkg::OFF_LIST_RANGE: rdata_d        = range_q;
          seq_pkg::OFF_LIST_QUERY: rdata_d[0]     = code_enabled(range_q.first, list_q);
          default:                 rdata_d        = 32'h0000_0000;
        endcase
      end
    end
  end

  //============================================================================
  // Event registers
  assign query_err = rd_en && paddr == seq_pkg::OFF_OQ_DATA && oq_cnt_q == 5'h00;

  always_comb
  begin
    ev_d = ev_q;
    if (rd_en)
    begin
      unique case (paddr)
        seq_pkg::OFF_EV_STD:  ev_d.std  = ev_q.std & ~rdata_q[7:0];
        seq_pkg::OFF_EV_OPER: ev_d.oper = ev_q.oper & ~rdata_q[15:0];
        seq_pkg::OFF_EV_MEAS: ev_d.meas = ev_q.meas & ~rdata_q[15:0];
        seq_pkg::OFF_EV_QUES: ev_d.ques = ev_q.ques & ~rdata_q[15:0];
        default:              ev_d      = ev_q;
      endcase
    end
    if (cls)
    begin
      ev_d = '0;
    end
    // Set wins over any clear in the same cycle
    ev_d      = ev_d | evt_set;
    ev_d.std[seq_pkg::STD_QUERY_ERR] = ev_d.std[seq_pkg::STD_QUERY_ERR] | query_err;
  end

  //============================================================================
  // Enable registers
  always_comb
  begin
    en_d = en_q;
    if (preset)
    begin
      en_d = '0;
    end
    if (wr_en)
    begin
      unique case (paddr)
        seq_pkg::OFF_EN_STD:  en_d.std  = pwdata[7:0];
        seq_pkg::OFF_EN_OPER: en_d.oper = pwdata[15:0];
        seq_pkg::OFF_EN_MEAS: en_d.meas = pwdata[15:0];
        seq_pkg::OFF_EN_QUES: en_d.ques = pwdata[15:0];
        default:              en_d      = en_d;
      endcase
    end
  end

  //============================================================================
  // Error code enable list
  always_comb
  begin
    int lo;
    int hi;
    int c;
    logic hit;
    lo      = 0;
    hi      = 0;
    c       = 0;
    hit     = 1'b0;
    range_d = range_q;
    list_d  = list_q;
    if (wr_en && paddr == seq_pkg::OFF_LIST_RANGE)
    begin
      range_d = pwdata;
    end
    if (wr_en && paddr == seq_pkg::OFF_LIST_CMD)
    begin
      // Reversed ranges are accepted as the same span
      lo = (range_q.first < range_q.last) ? int'(range_q.first) : int'(range_q.last);
      hi = (range_q.first < range_q.last) ? int'(range_q.last) : int'(range_q.first);
      for (int i = 0; i < seq_pkg::LIST_N; i++)
      begin
        c   = i - seq_pkg::LIST_BIAS;
        hit = (c >= lo) && (c <= hi);
        if (pwdata[seq_pkg::LC_ENABLE_NEW])
        begin
          list_d[i] = hit;
        end
        else if (pwdata[seq_pkg::LC_ENABLE_ADD])
        begin
          list_d[i] = list_q[i] | hit;
        end
        else if (pwdata[seq_pkg::LC_DISABLE])
        begin
          list_d[i] = list_q[i] & ~hit;
        end
        else if (pwdata[seq_pkg::LC_ENABLE_NONE])
        begin
          list_d[i] = 1'b0;
        end
      end
    end
  end

  //============================================================================
  // Error queue
  assign eq_push  = err_valid && code_enabled(err_code, list_q);
  assign eq_pop   = rd_en && (paddr == seq_pkg::OFF_EQ_NEXT || paddr == seq_pkg::OFF_EQ_CODE
                    || paddr == seq_pkg::OFF_EQ_ALL);
  assign eq_clear = cls || (wr_en && paddr == seq_pkg::OFF_CTRL && pwdata[seq_pkg::CTRL_EQ_CLEAR]);

  seq_err_fifo u_err_fifo (
    .clk       (pclk),
    .rst_n     (presetn),
    .push      (eq_push),
    .push_code (err_code),
    .pop       (eq_pop),
    .clear     (eq_clear),
    .head_code (eq_head),
    .count     (eq_count)
  );

  //============================================================================
  // Output queue; responses stall on resp_ready when full
  assign resp_ready = oq_cnt_q < seq_pkg::OQ_DEPTH;
  assign oq_push    = resp_valid && resp_ready;
  assign oq_pop     = rd_en && paddr == seq_pkg::OFF_OQ_DATA && oq_cnt_q != 5'h00;

  always_comb
  begin
    oq_mem_d = oq_mem_q;
    oq_wr_d  = oq_wr_q;
    oq_rd_d  = oq_rd_q;
    oq_cnt_d = oq_cnt_q;
    if (wr_en && paddr == seq_pkg::OFF_CTRL && pwdata[seq_pkg::CTRL_OQ_CLEAR])
    begin
      oq_wr_d  = 4'h0;
      oq_rd_d  = 4'h0;
      oq_cnt_d = 5'h00;
    end
    else
    begin
      if (oq_pop)
      begin
        oq_rd_d = oq_inc(oq_rd_q);
      end
      if (oq_push)
      begin
        oq_mem_d[oq_wr_q] = resp_data;
        oq_wr_d           = oq_inc(oq_wr_q);
      end
      oq_cnt_d = 5'(oq_cnt_q + {4'h0, oq_push} - {4'h0, oq_pop});
    end
  end

  //============================================================================
  // Status byte
  always_comb
  begin
    stb_d                  = 8'h00;
    stb_d[seq_pkg::SB_STD]  = |(ev_q.std & en_q.std);
    stb_d[seq_pkg::SB_OPER] = summary16(ev_q.oper, en_q.oper);
    stb_d[seq_pkg::SB_MEAS] = summary16(ev_q.meas, en_q.meas);
    stb_d[seq_pkg::SB_QUES] = summary16(ev_q.ques, en_q.ques);
    stb_d[seq_pkg::SB_MAV]  = oq_cnt_q != 5'h00;
    stb_d[seq_pkg::SB_EAV]  = eq_count != 4'h0;
    // No service enable here, so every summary feeds the master flag
    stb_d[seq_pkg::SB_MSS]  = |stb_d;
  end

  assign status_byte         = stb_q;
  assign master_summary_flag = stb_q[seq_pkg::SB_MSS];

  //============================================================================
  // Registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ev_q     <= '0;
      en_q     <= '0;
      range_q  <= '0;
      list_q   <= seq_pkg::LIST_RESET;
      rdata_q  <= 32'h0000_0000;
      stb_q    <= 8'h00;
      oq_wr_q  <= 4'h0;
      oq_rd_q  <= 4'h0;
      oq_cnt_q <= 5'h00;
      for (int i = 0; i < 16; i++)
      begin
        oq_mem_q[i] <= 32'h0000_0000;
      end
    end
    else
    begin
      ev_q     <= ev_d;
      en_q     <= en_d;
      range_q  <= range_d;
      list_q   <= list_d;
      rdata_q  <= rdata_d;
      stb_q    <= stb_d;
      oq_wr_q  <= oq_wr_d;
      oq_rd_q  <= oq_rd_d;
      oq_cnt_q <= oq_cnt_d;
      oq_mem_q <= oq_mem_d;
    end
  end

endmodule

// file: testbench/seq_top_assertions.sv
// Port checks of the status event and error queue block
`timescale 1ns/1ns
module seq_top_assertions (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [7:0]        paddr,
  input wire logic [31:0]       pwdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire seq_pkg::seq_evt_t evt_set,
  input wire logic              err_valid,
  input wire logic              resp_valid,
  input wire logic              resp_ready,
  input wire logic [7:0]        status_byte,
  input wire logic              master_summary_flag
);
  //==========
  // Helpers
  localparam logic [7:0] SUMS = 8'hA9;
  logic acc;
  logic ctl;
  assign acc = psel && penable && pwrite;
  assign ctl = acc && paddr == seq_pkg::OFF_CTRL;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Second cycle kept quiet so no read or push lands in the window
  sequence cls_wr; ctl && pwdata[seq_pkg::CTRL_CLS] && evt_set == '0 ##1 !penable && evt_set == '0; endsequence
  sequence pre_wr; ctl && pwdata[seq_pkg::CTRL_PRESET] ##1 !penable; endsequence
  sequence zero_wr; acc && paddr == seq_pkg::OFF_EN_OPER && pwdata[15:0] == 16'h0000 ##1 !penable; endsequence
  sequence eqc_wr;
    ctl && (pwdata[seq_pkg::CTRL_EQ_CLEAR] || pwdata[seq_pkg::CTRL_CLS]) && !err_valid ##1 !err_valid;
  endsequence
  sequence take; resp_valid && resp_ready && !penable ##1 !penable; endsequence
  //==========
  // Checks
  chk_cls_events: assert property (cls_wr |=> (status_byte & SUMS) == 8'h00)
    else $error("summary left after clear-status");
  chk_preset_enables: assert property (pre_wr |=> (status_byte & SUMS) == 8'h00)
    else $error("summary left after preset");
  chk_zero_enable: assert property (zero_wr |=> !status_byte[seq_pkg::SB_OPER])
    else $error("summary left after zero enable");
  chk_eav_clear: assert property (eqc_wr |=> !status_byte[seq_pkg::SB_EAV])
    else $error("error flag left after queue clear");
  chk_mav_set: assert property (take |=> status_byte[seq_pkg::SB_MAV])
    else $error("message flag missing after push");
  chk_mss_mirror: assert property (master_summary_flag == status_byte[seq_pkg::SB_MSS])
    else $error("master flag differs from status byte");
  chk_mss_or: assert property (status_byte[seq_pkg::SB_MSS] == |(status_byte & 8'hBD))
    else $error("master flag not the summary OR");
  chk_unmapped_err: assert property (psel && penable && paddr == 8'hFC |-> pslverr && pready)
    else $error("unmapped access not refused");
endmodule

// file: testbench/seq_resp_src.sv
// Behavioural source of query responses feeding the output queue
`timescale 1ns/1ns
module seq_resp_src (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        start,
  input  wire logic [4:0]  n_send,
  input  wire logic        slow,
  input  wire logic        resp_ready,
  output logic             resp_valid,
  output logic      [31:0] resp_data,
  output logic             done
);
  logic [4:0] left_q;
  assign done = (left_q == 5'h00);
  // Idle data toggles so a stale word never looks valid
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      left_q     <= 5'h00;
      resp_valid <= 1'b0;
      resp_data  <= 32'h0000_0000;
    end
    else if (start)
      left_q <= n_send;
    else if (resp_valid && resp_ready)
    begin
      left_q     <= left_q - 5'h01;
      resp_valid <= !slow && left_q > 5'h01;
      resp_data  <= (!slow && left_q > 5'h01) ? {16'hC0DE, 11'h000, left_q - 5'h01} : ~resp_data;
    end
    else if (!resp_valid && left_q != 5'h00)
    begin
      resp_valid <= 1'b1;
      resp_data  <= {16'hC0DE, 11'h000, left_q};
    end
    else if (!resp_valid)
      resp_data <= ~resp_data;
endmodule

// file: testbench/testbench.sv
// Top bench of the status event and error queue block
`timescale 1ns/1ns
module testbench;
  logic              pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic              err_valid, resp_valid, resp_ready, master_summary_flag;
  logic              start, slow, done;
  logic [4:0]        n_send;
  logic [7:0]        paddr, status_byte;
  logic [15:0]       err_code;
  logic [31:0]       pwdata, prdata, resp_data, v, m;
  seq_pkg::seq_evt_t evt_set;
  logic [15:0]       q[$];
  int                n_errors = 0;
  int                cmp_count = 0;
  int                cyc = 0;
  int                seed;
  int                sbit[4] = '{5, 7, 0, 3};

  seq_top seq_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .evt_set, .err_valid, .err_code, .resp_valid, .resp_data, .resp_ready, .status_byte, .master_summary_flag);
  seq_resp_src seq_resp_src_i (.pclk, .presetn, .start, .n_send, .slow, .resp_ready, .resp_valid, .resp_data, .done);

  //==========
  // Tasks
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e)
    begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Request held until pready seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] mk = 32'hFFFF_FFFF);
    logic [31:0] r;
    apb(1'b0, a, 32'h0000_0000, r);
    chk(r & mk, e);
  endtask
  task automatic lq(input logic [31:0] r, input int c, input logic e);
    wr(seq_pkg::OFF_LIST_RANGE, r);
    if (c >= 0)
      wr(seq_pkg::OFF_LIST_CMD, 32'h0000_0001 << c);
    rd(seq_pkg::OFF_LIST_QUERY, {31'h0, e}, 32'h0000_0001);
  endtask
  task automatic sb(input int b, input logic e);
    repeat (2) @(posedge pclk);
    chk({31'h0, status_byte[b]}, {31'h0, e});
  endtask
  task automatic ev(input seq_pkg::seq_evt_t x);
    evt_set <= x;
    @(posedge pclk);
    evt_set <= '0;
    @(posedge pclk);
  endtask
  task automatic er(input logic [15:0] c);
    err_valid <= 1'b1;
    err_code <= c;
    @(posedge pclk);
    err_valid <= 1'b0;
    err_code <= ~c;
    @(posedge pclk);
  endtask
  // Overflow marker takes the tenth slot, later pushes are lost
  function automatic logic [31:0] eq_exp(input int i);
    if (i >= q.size() || i > 9) return 32'h0000_0000;
    if (i == 9) return {16'h0000, seq_pkg::EQ_OVF_CODE};
    return {{16{q[i][15]}}, q[i]};
  endfunction
  task automatic oq(input logic [4:0] n, input logic s);
    slow <= s;
    n_send <= n;
    start <= 1'b1;
    @(posedge pclk);
    start <= 1'b0;
    @(posedge pclk);
    while (done !== 1'b1 && resp_ready === 1'b1)
      @(posedge pclk);
    rd(seq_pkg::OFF_OQ_COUNT, (n > 16) ? 32'd16 : 32'(n));
    for (int i = 0; i < n; i++)
      rd(seq_pkg::OFF_OQ_DATA, {16'hC0DE, 11'h000, n - 5'(i)});
    sb(seq_pkg::SB_MAV, 1'b0);
  endtask
  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  //==========
  // Clock, timeout, sequence
  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      n_errors++;
      finish_test();
    end
  end
  initial
  begin
    seed = 32'h5713ba4b;
    {presetn, psel, penable, pwrite, err_valid, start, slow} = 7'h00;
    {paddr, pwdata, err_code, n_send, evt_set} = '0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(seq_pkg::OFF_STB, 32'h0000_0000);
    rd(seq_pkg::OFF_EQ_CODE, 32'h0000_0000);
    rd(8'hFC, 32'h0000_0000);
    lq(32'h0096_0096, -1, 1'b0);
    lq(32'hFF9C_FF9C, -1, 1'b1);
    $display("reset test done");
    for (int k = 0; k < 4; k++)
    begin
      v = (k == 3) ? 32'hFFFF_FFFF : $random(seed);
      m = (k == 0) ? 32'h0000_00FF : 32'h0000_FFFF;
      ev(56'(v & m) << (16 * (3 - k)));
      wr(seq_pkg::OFF_EN_STD + 8'(4 * k), v);
      rd(seq_pkg::OFF_EN_STD + 8'(4 * k), v & m);
      sb(sbit[k], |(v & m));
      wr(seq_pkg::OFF_EN_STD + 8'(4 * k), 32'h0000_0000);
      sb(sbit[k], 1'b0);
      rd(seq_pkg::OFF_EV_STD + 8'(4 * k), v & m);
      rd(seq_pkg::OFF_EV_STD + 8'(4 * k), 32'h0000_0000);
    end
    $display("event test done");
    for (int p = 0; p < 2; p++)
    begin
      ev(56'h00_0001_0000_0000);
      wr(seq_pkg::OFF_EN_OPER, 32'h0000_0001);
      er(16'hFFFF);
      wr(seq_pkg::OFF_CTRL, 32'h0000_0001 << (p ? seq_pkg::CTRL_CLS : seq_pkg::CTRL_PRESET));
      rd(seq_pkg::OFF_EN_OPER, p);
      rd(seq_pkg::OFF_EV_OPER, !p);
      rd(seq_pkg::OFF_EQ_COUNT, p ? 32'd0 : 32'd1);
    end
    $display("preset test done");
    q = {16'h01F4};
    repeat (11) q.push_back(16'(-(1 + ($unsigned($random(seed)) % 900))));
    foreach (q[i]) er(q[i]);
    rd(seq_pkg::OFF_EQ_COUNT, 32'd10);
    sb(seq_pkg::SB_EAV, 1'b1);
    for (int i = 0; i < 11; i++)
      rd(i[0] ? seq_pkg::OFF_EQ_NEXT : seq_pkg::OFF_EQ_CODE, eq_exp(i));
    sb(seq_pkg::SB_EAV, 1'b0);
    q = {16'hFFF0, 16'h0005, 16'hFE00};
    foreach (q[i]) er(q[i]);
    rd(seq_pkg::OFF_EQ_ALL, {12'h000, 4'h3, q[0]}, 32'h000F_FFFF);
    wr(seq_pkg::OFF_CTRL, 32'h0000_0001 << seq_pkg::CTRL_EQ_CLEAR);
    rd(seq_pkg::OFF_EQ_COUNT, 32'd0);
    $display("error queue test done");
    lq(32'hFFFB_FFF6, seq_pkg::LC_ENABLE_NEW, 1'b1);
    lq(32'hFF9C_FF9C, -1, 1'b0);
    er(16'hFF9C);
    er(16'hFFF9);
    rd(seq_pkg::OFF_EQ_COUNT, 32'd1);
    lq(32'hFFFB_FFF6, seq_pkg::LC_DISABLE, 1'b0);
    lq(32'h0096_0096, seq_pkg::LC_ENABLE_ADD, 1'b1);
    lq(32'h0096_0096, seq_pkg::LC_ENABLE_NONE, 1'b0);
    er(16'h0096);
    rd(seq_pkg::OFF_EQ_COUNT, 32'd1);
    $display("list test done");
    oq(5'd3, 1'b1);
    oq(5'd17, 1'b0);
    rd(seq_pkg::OFF_OQ_DATA, 32'h0000_0000);
    $display("output queue test done");
    finish_test();
  end
endmodule

bind seq_top seq_top_assertions seq_top_assertions_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pready, .pslverr, .evt_set, .err_valid, .resp_valid, .resp_ready, .status_byte, .master_summary_flag);
